/* File: design/gpibad_pkg.sv */
// package: constants and carrier types for the bus addressing block
package gpibad_pkg;

    // ------------------------------------------------------------
    // command codes and groups
    // ------------------------------------------------------------
    localparam logic [6:0] LISTEN_BASE     = 7'h20;
    localparam logic [6:0] TALK_BASE       = 7'h40;
    localparam logic [1:0] LISTEN_GROUP    = 2'h1;
    localparam logic [1:0] TALK_GROUP      = 2'h2;
    localparam logic [4:0] ADDR_UNADDRESS  = 5'h1f;
    localparam logic [4:0] ADDR_MAX_VALID  = 5'h1e;
    localparam logic [6:0] CMD_UNLISTEN    = 7'h3f;
    localparam logic [6:0] CMD_UNTALK      = 7'h5f;
    localparam logic [6:0] ADDR_CMD_MAX    = 7'h0f;

    // ------------------------------------------------------------
    // defaults and timing
    // ------------------------------------------------------------
    localparam logic [4:0] DEFAULT_ADDR_A  = 5'h0c;
    localparam logic [4:0] DEFAULT_ADDR_B  = 5'h0d;
    localparam int         CLK_HZ          = 25_000_000;
    localparam int         SHOW_ADDR_MS    = 1000;
    localparam int         SHOW_ADDR_CYCLES = CLK_HZ / 1000 * SHOW_ADDR_MS;
    localparam logic [7:0] PREFIX_CHAR_0   = 8'h49;
    localparam logic [7:0] PREFIX_CHAR_1   = 8'h45;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       atn;
        logic       dav;
        logic [7:0] data;
    } gpibad_rx_type;

    typedef struct packed {
        logic       active;
        logic [7:0] char_hi;
        logic [7:0] char_lo;
        logic [3:0] tens;
        logic [3:0] ones;
    } gpibad_disp_type;

    typedef struct packed {
        logic       listen;
        logic       talk;
    } gpibad_state_type;

endpackage : gpibad_pkg

/* File: design/gpibad_sync.sv */
// two-flop synchroniser, parameterised width
`timescale 1ns/1ps
module gpibad_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    always_comb begin
        meta_next = din;
        sync_next = meta_reg;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            sync_reg <= '0;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign dout = sync_reg;
endmodule : gpibad_sync

/* File: design/gpibad_top.sv */
// bus addressing logic: address latch, listen/talk state, transceiver direction
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps
module gpibad_top #(
    parameter bit                 VARIANT_B      = 1'b0,
    parameter int unsigned        SHOW_CYCLES    = gpibad_pkg::SHOW_ADDR_CYCLES
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // address switches, first switch to fifth
    input  wire logic             addr_switch_lsb,
    input  wire logic [2:0]       addr_switch_mid,
    input  wire logic             addr_switch_msb,
    input  wire logic             addr_switch_valid,
    // bus receive side
    input  wire logic             bus_atn,
    input  wire logic             bus_dav,
    input  wire logic [7:0]       bus_data,
    // instrument side requests
    input  wire logic             send_req,
    // results
    output logic                  cmd_accept,
    output logic [6:0]            cmd_code,
    output logic                  send_grant,
    output gpibad_pkg::gpibad_state_type addr_state,
    output logic [4:0]            primary_addr,
    output gpibad_pkg::gpibad_disp_type  disp,
    // transceiver direction controls
    output logic                  dir_data,
    output logic                  dir_atn
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [15:0]               sync_out;
    gpibad_pkg::gpibad_rx_type rx;
    logic [4:0]                sw_val;
    logic                      sw_ok;

    gpibad_sync #(.WIDTH(16)) u_sync (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .din     ({addr_switch_valid, addr_switch_msb, addr_switch_mid, addr_switch_lsb,
                   bus_atn, bus_dav, bus_data}),
        .dout    (sync_out)
    );

    assign rx     = sync_out[9:0];
    assign sw_val = sync_out[14:10];
    assign sw_ok  = sync_out[15];

    // ------------------------------------------------------------
    // power-up address latch and display
    // ------------------------------------------------------------
    localparam logic [4:0] DEF_ADDR = VARIANT_B ? gpibad_pkg::DEFAULT_ADDR_B
                                                : gpibad_pkg::DEFAULT_ADDR_A;
    localparam logic [25:0] SHOW_LAST = 26'(SHOW_CYCLES - 1);

    logic [4:0]  paddr_reg;
    logic [4:0]  paddr_next;
    logic        latched_reg;
    logic        latched_next;
    logic [25:0] show_cnt_reg;
    logic [25:0] show_cnt_next;
    logic        show_reg;
    logic        show_next;

    always_comb begin
        paddr_next    = paddr_reg;
        latched_next  = latched_reg;
        show_cnt_next = show_cnt_reg;
        show_next     = show_reg;
        if (!latched_reg && sw_ok) begin
            latched_next = 1'b1;
            // 31 is refused so the default stays in force
            if (sw_val <= gpibad_pkg::ADDR_MAX_VALID) begin
                paddr_next = sw_val;
            end
            show_next = 1'b1;
        end else if (show_reg) begin
            if (show_cnt_reg == SHOW_LAST) begin
                show_next = 1'b0;
            end else begin
                show_cnt_next = show_cnt_reg + 26'h000_0001;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            paddr_reg    <= DEF_ADDR;
            latched_reg  <= 1'b0;
            show_cnt_reg <= '0;
            show_reg     <= 1'b0;
        end else begin
            paddr_reg    <= paddr_next;
            latched_reg  <= latched_next;
            show_cnt_reg <= show_cnt_next;
            show_reg     <= show_next;
        end
    end

    // ------------------------------------------------------------
    // command decode and addressing state
    // ------------------------------------------------------------
    logic       dav_d_reg;
    logic       listen_reg;
    logic       listen_next;
    logic       talk_reg;
    logic       talk_next;
    logic       accept_reg;
    logic       accept_next;
    logic [6:0] code_reg;
    logic [6:0] code_next;
    logic       strobe;
    logic [6:0] byte7;

    // bit 8 of the bus is ignored, as most instruments do
    assign byte7  = rx.data[6:0];
    assign strobe = rx.dav && !dav_d_reg;

    always_comb begin
        listen_next = listen_reg;
        talk_next   = talk_reg;
        accept_next = 1'b0;
        code_next   = code_reg;
        if (strobe && rx.atn) begin
            if (byte7 == gpibad_pkg::CMD_UNLISTEN) begin
                listen_next = 1'b0;
            end else if (byte7 == gpibad_pkg::CMD_UNTALK) begin
                talk_next = 1'b0;
            end else if (byte7[6:5] == gpibad_pkg::LISTEN_GROUP) begin
                if (byte7[4:0] == paddr_reg) begin
                    listen_next = 1'b1;
                end
            end else if (byte7[6:5] == gpibad_pkg::TALK_GROUP) begin
                talk_next = (byte7[4:0] == paddr_reg);
            end else if (byte7 <= gpibad_pkg::ADDR_CMD_MAX && listen_reg) begin
                accept_next = 1'b1;
                code_next   = byte7;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dav_d_reg  <= 1'b0;
            listen_reg <= 1'b0;
            talk_reg   <= 1'b0;
            accept_reg <= 1'b0;
            code_reg   <= '0;
        end else begin
            dav_d_reg  <= rx.dav;
            listen_reg <= listen_next;
            talk_reg   <= talk_next;
            accept_reg <= accept_next;
            code_reg   <= code_next;
        end
    end

    // ------------------------------------------------------------
    // display digits
    // ------------------------------------------------------------
    logic [3:0] tens_reg;
    logic [3:0] tens_next;
    logic [3:0] ones_reg;
    logic [3:0] ones_next;

    // digits trail the address and the display strobe by one cycle
    always_comb begin
        if (paddr_reg >= 5'h1e) begin
            tens_next = 4'h3;
            ones_next = 4'(paddr_reg - 5'h1e);
        end else if (paddr_reg >= 5'h14) begin
            tens_next = 4'h2;
            ones_next = 4'(paddr_reg - 5'h14);
        end else if (paddr_reg >= 5'h0a) begin
            tens_next = 4'h1;
            ones_next = 4'(paddr_reg - 5'h0a);
        end else begin
            tens_next = 4'h0;
            ones_next = 4'(paddr_reg);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tens_reg <= 4'h0;
            ones_reg <= 4'h0;
        end else begin
            tens_reg <= tens_next;
            ones_reg <= ones_next;
        end
    end

    // ------------------------------------------------------------
    // transmit gating and registered outputs
    // ------------------------------------------------------------
    logic grant_reg;
    logic grant_next;
    logic dir_reg;
    logic dir_next;

    // only a talker with attention released may drive the data lines
    always_comb begin
        grant_next = send_req && talk_reg && !rx.atn;
        dir_next   = send_req && talk_reg && !rx.atn;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            grant_reg <= 1'b0;
            dir_reg   <= 1'b0;
        end else begin
            grant_reg <= grant_next;
            dir_reg   <= dir_next;
        end
    end

    assign cmd_accept        = accept_reg;
    assign cmd_code          = code_reg;
    assign send_grant        = grant_reg;
    assign addr_state.listen = listen_reg;
    assign addr_state.talk   = talk_reg;
    assign primary_addr      = paddr_reg;
    assign dir_data          = dir_reg;
    assign dir_atn           = 1'b0;
    assign disp.active       = show_reg;
    assign disp.char_hi      = gpibad_pkg::PREFIX_CHAR_0;
    assign disp.char_lo      = gpibad_pkg::PREFIX_CHAR_1;
    assign disp.tens         = tens_reg;
    assign disp.ones         = ones_reg;
endmodule : gpibad_top

/* File: verif/gpibad_props.sv */
// checker: addressing state, transceiver direction and display timing
`timescale 1ns/1ps
module gpibad_props #(
    parameter int unsigned SHOW_CYCLES = 20
) (
    // clock and reset
    input wire logic                        sys_clk,
    input wire logic                        rst_n,
    // bus side and requests
    input wire logic                        bus_atn,
    input wire logic                        bus_dav,
    input wire logic [7:0]                  bus_data,
    input wire logic                        send_req,
    // results
    input wire logic                        cmd_accept,
    input wire logic [6:0]                  cmd_code,
    input wire logic                        send_grant,
    input wire gpibad_pkg::gpibad_state_type addr_state,
    input wire logic [4:0]                  primary_addr,
    input wire gpibad_pkg::gpibad_disp_type  disp,
    input wire logic                        dir_data,
    input wire logic                        dir_atn
);
    logic [31:0] show_cnt_reg;
    logic        seen_reg;
    // seen_reg rises once the display has started, one cycle after the power-up latch
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            show_cnt_reg <= 32'h0000_0000;
            seen_reg     <= 1'b0;
        end else begin
            show_cnt_reg <= disp.active ? show_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
            seen_reg     <= seen_reg | disp.active;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_addr_byte(logic [1:0] grp);
        $rose(bus_dav) && bus_atn && (bus_data[6:5] == grp);
    endsequence
    chk_listen_own: assert property (s_addr_byte(2'b01) ##0 (bus_data[4:0] == primary_addr)
        |-> ##[2:6] addr_state.listen) else $error("listen address not taken");
    chk_talk_other: assert property (s_addr_byte(2'b10) ##0 (bus_data[4:0] != primary_addr)
        |-> ##[2:6] !addr_state.talk) else $error("talker kept after foreign talk");
    chk_cmd_listener: assert property (cmd_accept
        |-> addr_state.listen && (cmd_code <= gpibad_pkg::ADDR_CMD_MAX))
        else $error("command taken while not listener");
    chk_grant_talker: assert property (send_grant
        |-> $past(send_req) && $past(addr_state.talk)) else $error("send granted without talk");
    chk_dir_grant: assert property ((dir_data == send_grant) && (!dir_data || !$past(bus_atn, 3)))
        else $error("data direction differs from grant");
    chk_atn_receive: assert property (dir_atn == 1'b0)
        else $error("attention transceiver driving");
    chk_addr_valid: assert property (primary_addr != gpibad_pkg::ADDR_UNADDRESS)
        else $error("address 31 latched");
    chk_addr_once: assert property (seen_reg |-> $stable(primary_addr))
        else $error("address changed after power-up");
    chk_show_length: assert property ($fell(disp.active) |-> show_cnt_reg == SHOW_CYCLES)
        else $error("address display length wrong");
endmodule : gpibad_props

bind gpibad_top gpibad_props #(.SHOW_CYCLES(SHOW_CYCLES)) i_gpibad_props (
    .sys_clk(sys_clk), .rst_n(rst_n), .bus_atn(bus_atn), .bus_dav(bus_dav),
    .bus_data(bus_data), .send_req(send_req), .cmd_accept(cmd_accept),
    .cmd_code(cmd_code), .send_grant(send_grant), .addr_state(addr_state),
    .primary_addr(primary_addr), .disp(disp), .dir_data(dir_data), .dir_atn(dir_atn));

/* File: verif/gpibad_ctrl_model.sv */
// partner: bus controller that sends command and data bytes
`timescale 1ns/1ps
module gpibad_ctrl_model (
    // clock
    input  wire logic  sys_clk,
    // bus lines seen by the instrument
    output logic       bus_atn,
    output logic       bus_dav,
    output logic [7:0] bus_data
);
    initial begin
        bus_atn  = 1'b0;
        bus_dav  = 1'b0;
        bus_data = 8'h00;
    end
    // dav stays low 4 cycles after each byte so the receiver sees a clean edge
    task automatic send_byte(input logic atn, input logic [7:0] code, input int hold);
        @(posedge sys_clk);
        bus_atn  <= atn;
        bus_data <= code;
        bus_dav  <= 1'b1;
        repeat (hold) @(posedge sys_clk);
        bus_dav  <= 1'b0;
        bus_data <= ~code;
        repeat (4) @(posedge sys_clk);
        bus_atn  <= 1'b0;
    endtask : send_byte
endmodule : gpibad_ctrl_model

/* File: verif/tb_top.sv */
// testbench: power-up latch, addressing, command and send gating
`timescale 1ns/1ps
module tb_top;
    logic sys_clk, rst_n, sw_lsb, sw_msb, sw_valid, bus_atn, bus_dav, send_req;
    logic [2:0] sw_mid;
    logic [7:0] bus_data;
    logic cmd_accept, send_grant, dir_data, dir_atn;
    logic [6:0] cmd_code;
    logic [4:0] primary_addr;
    logic [4:0] primary_addr_b;
    gpibad_pkg::gpibad_state_type addr_state;
    gpibad_pkg::gpibad_disp_type  disp;
    int mismatches = 0, n_compared = 0, n_acc = 0;

    gpibad_ctrl_model i_ctrl (.sys_clk(sys_clk), .bus_atn(bus_atn), .bus_dav(bus_dav),
        .bus_data(bus_data));
    gpibad_top #(.VARIANT_B(1'b0), .SHOW_CYCLES(20)) i_gpibad_top (.sys_clk(sys_clk),
        .rst_n(rst_n), .addr_switch_lsb(sw_lsb), .addr_switch_mid(sw_mid),
        .addr_switch_msb(sw_msb), .addr_switch_valid(sw_valid), .bus_atn(bus_atn),
        .bus_dav(bus_dav), .bus_data(bus_data), .send_req(send_req),
        .cmd_accept(cmd_accept), .cmd_code(cmd_code), .send_grant(send_grant),
        .addr_state(addr_state), .primary_addr(primary_addr), .disp(disp),
        .dir_data(dir_data), .dir_atn(dir_atn));
    // second build variant shares every input; only its default address is compared
    gpibad_top #(.VARIANT_B(1'b1), .SHOW_CYCLES(20)) i_gpibad_top_b (.sys_clk(sys_clk),
        .rst_n(rst_n), .addr_switch_lsb(sw_lsb), .addr_switch_mid(sw_mid),
        .addr_switch_msb(sw_msb), .addr_switch_valid(sw_valid), .bus_atn(bus_atn),
        .bus_dav(bus_dav), .bus_data(bus_data), .send_req(send_req),
        .cmd_accept(), .cmd_code(), .send_grant(), .addr_state(),
        .primary_addr(primary_addr_b), .disp(), .dir_data(), .dir_atn());

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (cmd_accept === 1'b1) n_acc++;

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
        n_compared++;
    endtask : check
    task automatic send(input logic atn, input logic [7:0] c, input int hold);
        i_ctrl.send_byte(atn, c, hold);
        @(negedge sys_clk);
    endtask : send
    task automatic power_up(input logic [4:0] sw);
        @(posedge sys_clk);
        rst_n    <= 1'b0;
        sw_valid <= 1'b0;
        {sw_msb, sw_mid, sw_lsb} <= sw;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(negedge sys_clk);
        check(8'(primary_addr), 8'h0c);
        check(8'(primary_addr_b), 8'h0d);
        @(posedge sys_clk);
        sw_valid <= 1'b1;
        repeat (6) @(negedge sys_clk);
    endtask : power_up
    task automatic t_power;
        power_up(5'h1e);
        check(8'(primary_addr), 8'h1e);
        check({7'h00, disp.active}, 8'h01);
        check({disp.tens, disp.ones}, 8'h30);
        check(disp.char_hi, gpibad_pkg::PREFIX_CHAR_0);
        check(disp.char_lo, gpibad_pkg::PREFIX_CHAR_1);
        @(posedge sys_clk);
        {sw_msb, sw_mid, sw_lsb} <= 5'h03;
        repeat (30) @(negedge sys_clk);
        check(8'(primary_addr), 8'h1e);
        check({7'h00, disp.active}, 8'h00);
        $display("test power done");
    endtask : t_power
    task automatic t_listen;
        logic [7:0] codes [3] = '{8'h01, 8'h84, 8'h08};
        int base;
        base = n_acc;
        send(1'b1, 8'h04, 2);
        check(8'(n_acc - base), 8'h00);
        send(1'b1, 8'h3e, 6);
        send(1'b1, 8'h2c, 2);
        check({7'h00, addr_state.listen}, 8'h01);
        foreach (codes[i]) begin
            send(1'b1, codes[i], 2);
            check({1'b0, cmd_code}, codes[i] & 8'h7f);
        end
        send(1'b0, 8'h08, 2);
        send(1'b1, 8'h3f, 2);
        check({7'h00, addr_state.listen}, 8'h00);
        send(1'b1, 8'h01, 2);
        check(8'(n_acc - base), 8'h03);
        $display("test listen done");
    endtask : t_listen
    task automatic t_talk;
        @(posedge sys_clk);
        send_req <= 1'b1;
        repeat (4) @(negedge sys_clk);
        check({7'h00, send_grant}, 8'h00);
        send(1'b1, 8'h5e, 2);
        repeat (4) @(negedge sys_clk);
        check({6'h00, dir_data, send_grant}, 8'h03);
        check({7'h00, dir_atn}, 8'h00);
        send(1'b1, 8'h5f, 2);
        check({7'h00, addr_state.talk}, 8'h00);
        send(1'b1, 8'h5e, 2);
        send(1'b1, 8'h45, 2);
        repeat (4) @(negedge sys_clk);
        check({6'h00, addr_state.talk, send_grant}, 8'h00);
        @(posedge sys_clk);
        send_req <= 1'b0;
        $display("test talk done");
    endtask : t_talk
    task automatic t_repower;
        power_up(5'h1f);
        check(8'(primary_addr), 8'h0c);
        check(8'(primary_addr_b), 8'h0d);
        power_up(5'h05);
        send(1'b1, 8'h25, 2);
        check({3'h0, primary_addr}, 8'h05);
        check({disp.tens, disp.ones}, 8'h05);
        check({7'h00, addr_state.listen}, 8'h01);
        $display("test repower done");
    endtask : t_repower
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    initial begin
        {rst_n, sw_lsb, sw_mid, sw_msb, sw_valid, send_req} = 8'h00;
        t_power();
        t_listen();
        t_talk();
        t_repower();
        results();
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        results();
    end
endmodule : tb_top
